//--- rtl/sdc_ctrl.sv
// sigma-delta converter control: rates, decimation, calibration, standby, ahb-lite registers
// Overview of operation
// R01 - modulator clock is master clock over 512
// R02 - input sampling 256 divider times gain, capped 8
// R03 - higher gain: multiple samples plus capacitor scaling
// R04 - sinc3 decimator refreshes result once per notch
// R05 - notch programmable 9.76 Hz to 1.028 kHz
// R06 - host reads results no faster than updates
// R07 - calibration request accepted at any moment
// R08 - self and system calibration modes supported
// R09 - background mode refreshes coefficients by itself (code refreshes the offset coefficient only)
// R10 - host reads and overwrites coefficients, conversions use them
// R11 - standby halts conversion activity
// R12 - results invalid until filter has settled
// R13 - more ones give more positive result
// R14 - notch defaults to 60 Hz after reset
// R15 - settling takes four output periods
// R16 - one bit per modulator cycle, strobe per word
`timescale 1ns/1ns
module sdc_ctrl #(
    parameter int BG_WORDS = 64,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic mod_bit,
    output logic mod_clk_en,
    output logic samp_en,
    output logic [2:0] cap_ratio_sel,
    output logic chan_sel,
    output logic [1:0] cal_input,
    output logic cal_sys,
    output logic standby,
    output logic result_stb
);
    if (BG_WORDS < 1 || BG_WORDS > 65535) begin : g_bad_bg
        $error("background interval out of range");
    end
    typedef enum logic [1:0] {CS_IDLE, CS_ZERO, CS_FULL, CS_DIV} sdc_cstate_type;
    typedef struct packed {
        logic [11:0] fs;
        logic [2:0] gain;
        logic chan;
        logic stby;
        sdc_pkg::sdc_calmode_type calm;
        logic [31:0] off;
        logic [23:0] gcf;
        logic [8:0] div;
        sdc_cstate_type cst;
        logic bg;
        logic [15:0] bgcnt;
        logic [2:0] wcnt;
        logic restart;
        logic pend;
        logic [31:0] pdat;
        logic ovr;
        logic wr;
        logic [7:0] aq;
        logic [31:0] rdat;
        logic [55:0] rem;
        logic [31:0] span;
        logic [4:0] qb;
    } sdc_top_st_type;
    localparam sdc_top_st_type ST_RESET = '{
        fs: 12'(sdc_pkg::FS_DEFAULT), gcf: sdc_pkg::GAIN_UNITY,
        calm: sdc_pkg::SDC_CAL_SELF, cst: CS_IDLE, default: '0};
    localparam logic [2:0] SETTLE = 3'(sdc_pkg::SETTLE_WORDS);

    sdc_top_st_type st_q, st_d;
    sdc_strm_if #(.W(36)) dec ();
    sdc_strm_if #(.W(32)) fin ();
    logic ap, fifo_valid, fifo_pop;
    logic [31:0] fifo_data, raw, corr, rv;
    logic [1:0] gmin;
    logic [7:0] smask;
    logic [11:0] fs_new;
    logic [32:0] diff;
    logic [57:0] prod;
    logic [55:0] trial;

    sdc_sinc3 #(.ACC_W(36), .CNT_W(12)) u_dec (
        .core_clk(core_clk),
        .resetn(resetn),
        .clear(st_q.restart),
        .bit_en(mod_clk_en),
        .bit_in(mod_bit),
        .ratio(st_q.fs),
        .res(dec)
    );
    sdc_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .resetn(resetn),
        .wr(fin),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // rate enables from one divider; samples per modulator cycle follow the gain, capped at GAIN_LOG_CAP
    assign gmin = (st_q.gain > 3'(sdc_pkg::GAIN_LOG_CAP)) ? 2'(sdc_pkg::GAIN_LOG_CAP) : st_q.gain[1:0]; // see R02
    assign smask = 8'(sdc_pkg::SAMP_BASE - 1) >> gmin;
    assign mod_clk_en = !st_q.stby && st_q.div == 9'(sdc_pkg::MOD_DIV - 1); // see R01 R11 R16
    assign samp_en = !st_q.stby && (st_q.div[7:0] & smask) == smask; // see R02 R03
    assign cap_ratio_sel = st_q.gain; // see R03
    assign chan_sel = st_q.chan;
    assign standby = st_q.stby;
    assign cal_sys = st_q.calm == sdc_pkg::SDC_CAL_SYS && st_q.cst != CS_IDLE; // see R08
    assign cal_input = st_q.cst == CS_ZERO ? sdc_pkg::SDC_IN_ZERO :
                       st_q.cst == CS_FULL ? sdc_pkg::SDC_IN_FULL : sdc_pkg::SDC_IN_NORMAL;
    assign result_stb = dec.valid;
    assign dec.ready = 1'b1;
    assign fin.valid = st_q.pend;
    assign fin.data = st_q.pdat;

    // bus handshake; reads are zero wait from a flopped word
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_q.rdat;
    assign ap = hsel && htrans[1] && hready;
    assign fifo_pop = ap && !hwrite && haddr[7:0] == sdc_pkg::REG_DATA;

    // offset and gain correction of each raw word
    assign raw = dec.data[sdc_pkg::RAW_SHIFT +: 32];
    assign diff = {1'b0, raw} - {1'b0, st_q.off}; // see R10
    assign prod = 58'($signed(diff) * $signed({1'b0, st_q.gcf}));
    assign corr = prod[sdc_pkg::GAIN_FRAC +: 32];
    assign trial = 56'(st_q.span) << st_q.qb;

    // notch code clamped into its programmable range
    always_comb begin
        fs_new = hwdata[sdc_pkg::CTRL_FS_LSB +: 12];
        if (fs_new < 12'(sdc_pkg::FS_MIN)) begin // see R05
            fs_new = 12'(sdc_pkg::FS_MIN);
        end else if (fs_new > 12'(sdc_pkg::FS_MAX)) begin
            fs_new = 12'(sdc_pkg::FS_MAX);
        end
    end

    // register read mux
    always_comb begin
        rv = '0;
        case (haddr[7:0])
            sdc_pkg::REG_CTRL: begin
                rv[sdc_pkg::CTRL_FS_LSB +: 12] = st_q.fs;
                rv[sdc_pkg::CTRL_GAIN_LSB +: 3] = st_q.gain;
                rv[sdc_pkg::CTRL_CHAN_BIT] = st_q.chan;
                rv[sdc_pkg::CTRL_STBY_BIT] = st_q.stby;
                rv[sdc_pkg::CTRL_CALM_LSB +: 2] = st_q.calm;
            end
            sdc_pkg::REG_STATUS: begin
                rv[4:0] = {st_q.ovr, st_q.stby, st_q.wcnt == SETTLE, st_q.cst != CS_IDLE, fifo_valid};
            end
            sdc_pkg::REG_DATA: rv = fifo_valid ? fifo_data : 32'h0000_0000; // see R06
            sdc_pkg::REG_OFFSET: rv = st_q.off; // see R10
            sdc_pkg::REG_GAIN: rv[23:0] = st_q.gcf;
            default: rv = '0;
        endcase
    end

    // next state of the whole block
    always_comb begin
        st_d = st_q;
        st_d.restart = 1'b0;
        st_d.div = st_q.stby ? 9'h000 : st_q.div + 9'h001;
        st_d.wr = ap && hwrite;
        if (ap) begin
            st_d.aq = haddr[7:0];
        end
        if (ap && !hwrite) begin
            st_d.rdat = rv;
        end
        if (fin.ready) begin
            st_d.pend = 1'b0;
        end
        // coefficient and status writes
        if (st_q.wr) begin
            case (st_q.aq)
                sdc_pkg::REG_OFFSET: st_d.off = hwdata; // see R10
                sdc_pkg::REG_GAIN: st_d.gcf = hwdata[23:0];
                sdc_pkg::REG_STATUS: st_d.ovr = st_q.ovr && !hwdata[sdc_pkg::STAT_OVR_BIT];
                default: st_d.ovr = st_q.ovr;
            endcase
        end
        // each decimator word; early words after a restart are discarded
        if (dec.valid) begin
            if (st_q.wcnt < SETTLE) begin
                st_d.wcnt = st_q.wcnt + 3'h1;
            end
            if (st_q.wcnt >= SETTLE - 3'h1) begin // see R12 R15
                case (st_q.cst)
                    CS_IDLE: begin
                        if (st_q.pend && !fin.ready) begin
                            st_d.ovr = 1'b1;
                        end
                        st_d.pend = 1'b1;
                        st_d.pdat = corr;
                        if (st_q.calm == sdc_pkg::SDC_CAL_BG) begin // see R09
                            st_d.bgcnt = st_q.bgcnt + 16'h0001;
                            if (st_q.bgcnt == 16'(BG_WORDS - 1)) begin
                                st_d.bgcnt = '0;
                                st_d.cst = CS_ZERO;
                                st_d.bg = 1'b1;
                                st_d.restart = 1'b1;
                                st_d.wcnt = '0;
                            end
                        end
                    end
                    CS_ZERO: begin
                        st_d.off = raw; // see R08
                        st_d.cst = st_q.bg ? CS_IDLE : CS_FULL;
                        st_d.restart = 1'b1;
                        st_d.wcnt = '0;
                    end
                    CS_FULL: begin
                        st_d.span = raw - st_q.off;
                        st_d.rem = 56'h1 << sdc_pkg::DIV_NUM_LOG;
                        st_d.qb = 5'h17;
                        st_d.restart = 1'b1;
                        st_d.wcnt = '0;
                        st_d.cst = (raw > st_q.off) ? CS_DIV : CS_IDLE;
                        if (raw > st_q.off) begin
                            st_d.gcf = '0;
                        end
                    end
                    default: st_d.cst = st_q.cst;
                endcase
            end
        end
        // gain coefficient by restoring division, one quotient bit a cycle
        if (st_q.cst == CS_DIV) begin
            if (st_q.rem >= trial) begin
                st_d.rem = st_q.rem - trial;
                st_d.gcf[st_q.qb] = 1'b1;
            end
            st_d.qb = st_q.qb - 5'h01;
            if (st_q.qb == 5'h00) begin
                st_d.cst = CS_IDLE;
            end
        end
        // control write: new setup restarts the filter, go starts calibration
        if (st_q.wr && st_q.aq == sdc_pkg::REG_CTRL) begin
            st_d.fs = fs_new; // see R05
            st_d.gain = hwdata[sdc_pkg::CTRL_GAIN_LSB +: 3];
            st_d.chan = hwdata[sdc_pkg::CTRL_CHAN_BIT];
            st_d.stby = hwdata[sdc_pkg::CTRL_STBY_BIT]; // see R11
            st_d.calm = hwdata[sdc_pkg::CTRL_CALM_LSB +: 2] == 2'h3 ? sdc_pkg::SDC_CAL_SELF :
                        sdc_pkg::sdc_calmode_type'(hwdata[sdc_pkg::CTRL_CALM_LSB +: 2]);
            st_d.restart = 1'b1;
            st_d.wcnt = '0;
            st_d.bgcnt = '0;
            if (hwdata[sdc_pkg::CTRL_GO_BIT]) begin // see R07
                st_d.cst = CS_ZERO;
                st_d.bg = 1'b0;
            end
        end
        // standby holds the filter cleared
        if (st_q.stby) begin // see R11
            st_d.restart = 1'b1;
            st_d.wcnt = '0;
        end
    end

    // state register; reset loads the 60 Hz notch and unity gain
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_RESET; // see R14
        end else begin
            st_q <= st_d;
        end
    end

    // helper counters watched by the checks below
    logic [9:0] gap_q;
    logic seen_q;
    logic [4:0] scnt_q;
    logic [11:0] mcnt_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gap_q <= '0;
            seen_q <= 1'b0;
            scnt_q <= '0;
            mcnt_q <= '0;
        end else begin
            gap_q <= (mod_clk_en || st_q.stby) ? 10'h000 : gap_q + 10'h001;
            seen_q <= !st_q.stby && st_d.gain == st_q.gain && (seen_q || mod_clk_en); // a gain change skips one period
            scnt_q <= (mod_clk_en || st_q.stby) ? 5'h00 : scnt_q + 5'(samp_en);
            mcnt_q <= (st_q.restart || dec.valid) ? 12'h000 : mcnt_q + 12'(mod_clk_en);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_mod_rate: assert property ( // see R01
        mod_clk_en && seen_q |-> gap_q == 10'h1ff)
        else $error("modulator enable not every 512 cycles");
    chk_samp_count: assert property ( // see R02
        mod_clk_en && seen_q && $stable(st_q.gain) |-> scnt_q + 5'h01 == 5'h02 << gmin)
        else $error("wrong input samples per modulator cycle");
    chk_word_rate: assert property ( // see R04
        dec.valid |-> mcnt_q == $past(st_q.fs))
        else $error("result word not once per notch period");
    chk_fs_range: assert property ( // see R05
        st_q.fs >= 12'(sdc_pkg::FS_MIN) && st_q.fs <= 12'(sdc_pkg::FS_MAX))
        else $error("notch code outside programmable range");
    chk_cal_go: assert property ( // see R07
        st_q.wr && st_q.aq == sdc_pkg::REG_CTRL && hwdata[sdc_pkg::CTRL_GO_BIT]
        |=> cal_input == sdc_pkg::SDC_IN_ZERO && st_q.restart)
        else $error("calibration request not started");
    chk_cal_order: assert property ( // see R08
        cal_input == sdc_pkg::SDC_IN_FULL && dec.valid && st_q.wcnt == SETTLE - 3'h1
        |=> cal_input != sdc_pkg::SDC_IN_FULL && st_q.restart)
        else $error("full-scale phase stalled after settling");
    chk_coef_wr: assert property ( // see R10
        st_q.wr && st_q.aq == sdc_pkg::REG_OFFSET && !dec.valid |=> st_q.off == $past(hwdata))
        else $error("offset coefficient write lost");
    chk_stby_quiet: assert property ( // see R11
        standby [*3] |-> !mod_clk_en && !samp_en && !result_stb)
        else $error("activity during standby");
    chk_settle_drop: assert property ( // see R12
        dec.valid && st_q.wcnt < SETTLE - 3'h1 |=> !$rose(st_q.pend))
        else $error("unsettled word delivered");

    cov_cal_done: cover property (st_q.cst == CS_DIV ##1 st_q.cst == CS_IDLE);
    cov_bg_cal: cover property (st_q.bg && st_q.cst == CS_ZERO);
    cov_word_read: cover property (fifo_pop && fifo_valid);
endmodule

//--- rtl/sdc_pkg.sv
// shared constants and types of the sigma-delta converter control block
package sdc_pkg;
    // master clock and the reference clock that the notch figures assume
    localparam int MCLK_HZ = 125_000_000;
    localparam int REF_MCLK_HZ = 10_000_000;
    // modulator and input sampling dividers
    localparam int MOD_DIV = 512;
    localparam int SAMP_BASE = 256;
    localparam int GAIN_LOG_CAP = 3;
    // notch code range and power-on default
    localparam int NOTCH_DEF_HZ = 60;
    localparam int FS_DEFAULT = REF_MCLK_HZ / (MOD_DIV * NOTCH_DEF_HZ);
    localparam int FS_MIN = 19;
    localparam int FS_MAX = 2000;
    localparam int SETTLE_WORDS = 4;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_OFFSET = 8'h0c;
    localparam logic [7:0] REG_GAIN = 8'h10;
    // control fields
    localparam int CTRL_FS_LSB = 0;
    localparam int CTRL_GAIN_LSB = 12;
    localparam int CTRL_CHAN_BIT = 15;
    localparam int CTRL_STBY_BIT = 16;
    localparam int CTRL_CALM_LSB = 17;
    localparam int CTRL_GO_BIT = 19;
    // status fields
    localparam int STAT_OVR_BIT = 4;
    // calibration arithmetic
    localparam int RAW_SHIFT = 4;
    localparam int GAIN_FRAC = 22;
    localparam logic [23:0] GAIN_UNITY = 24'h40_0000;
    localparam int DIV_NUM_LOG = 45;
    typedef enum logic [1:0] {SDC_CAL_SELF, SDC_CAL_SYS, SDC_CAL_BG} sdc_calmode_type;
    typedef enum logic [1:0] {SDC_IN_NORMAL, SDC_IN_ZERO, SDC_IN_FULL} sdc_calin_type;
endpackage

//--- rtl/sdc_strm_if.sv
// valid/ready word stream between the converter's own modules
`timescale 1ns/1ns
interface sdc_strm_if #(parameter int W = 32);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- rtl/sdc_fifo.sv
// result word fifo with valid and ready on both sides
`timescale 1ns/1ns
module sdc_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic resetn,
    sdc_strm_if.snk wr,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sdc_fifo_st_type;
    sdc_fifo_st_type st_q, st_d;
    logic push, pop;

    // handshakes come straight from the fill count
    assign wr.ready = st_q.cnt != (AW+1)'(DEPTH);
    assign out_valid = st_q.cnt != '0;
    assign out_data = st_q.mem[st_q.rp];
    assign push = wr.valid && wr.ready;
    assign pop = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = wr.data;
            st_d.wp = st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = st_q.rp + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    chk_fifo_bound: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q.cnt == (AW+1)'(DEPTH) |-> !wr.ready ##1 st_q.cnt <= (AW+1)'(DEPTH))
        else $error("fifo accepted a word while full");
    cov_fifo_full: cover property (@(posedge core_clk) disable iff (!resetn) !wr.ready);
endmodule

//--- rtl/sdc_sinc3.sv
// third-order sinc decimator for the one-bit modulator stream
`timescale 1ns/1ns
module sdc_sinc3 #(
    parameter int ACC_W = 36,
    parameter int CNT_W = 12
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic bit_en,
    input wire logic bit_in,
    input wire logic [CNT_W-1:0] ratio,
    sdc_strm_if.src res
);
    if (ACC_W < 3 * CNT_W) begin : g_bad_width
        $error("accumulator too narrow for the decimation ratio");
    end
    typedef struct packed {
        logic [ACC_W-1:0] i1, i2, i3;
        logic [ACC_W-1:0] d1, d2, d3;
        logic [CNT_W-1:0] cnt;
        logic [ACC_W-1:0] dat;
        logic vld;
    } sdc_dec_st_type;
    sdc_dec_st_type st_q, st_d;
    logic [ACC_W-1:0] c1, c2;

    assign res.valid = st_q.vld;
    assign res.data = st_q.dat;

    // integrate at modulator rate, differentiate at the output rate
    always_comb begin
        st_d = st_q;
        st_d.vld = 1'b0;
        c1 = st_q.i3 - st_q.d1;
        c2 = c1 - st_q.d2;
        if (clear) begin
            st_d = '0;
        end else if (bit_en) begin
            st_d.i1 = st_q.i1 + ACC_W'(bit_in); // ones density raises the result, see R13
            st_d.i2 = st_q.i2 + st_q.i1;
            st_d.i3 = st_q.i3 + st_q.i2;
            st_d.cnt = st_q.cnt + 1'b1;
            if (st_q.cnt >= ratio - 1'b1) begin // one word per notch period, see R04
                st_d.cnt = '0;
                st_d.d1 = st_q.i3;
                st_d.d2 = c1;
                st_d.d3 = c2;
                st_d.dat = c2 - st_q.d3;
                st_d.vld = 1'b1; // see R16
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    chk_word_pulse: assert property (@(posedge core_clk) disable iff (!resetn) // see R16
        st_q.vld |=> !st_q.vld [*2])
        else $error("result strobe longer than one cycle");
    cov_ones_word: cover property (@(posedge core_clk) disable iff (!resetn) st_q.vld && st_q.dat != '0);
endmodule

//--- tb/sdc_mod_model.sv
// modulator stand-in: first-order bit stream at a set ones density
`timescale 1ns/1ns
module sdc_mod_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic mod_clk_en,
    input wire logic [1:0] cal_input,
    input wire logic [8:0] density,
    output logic mod_bit
);
    logic [7:0] acc_q;
    logic [9:0] sum;
    logic tog_q;
    logic cur;
    // density is ones out of 256; calibration phases force zero and full scale
    assign sum = {2'b00, acc_q} + {1'b0, density};
    assign cur = (cal_input == 2'd1) ? 1'b0 : ((cal_input == 2'd2) ? 1'b1 : (sum >= 10'd256)); // ones rise
    // between modulator cycles the line toggles, so a stale sample is never a lucky match
    assign mod_bit = mod_clk_en ? cur : tog_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acc_q <= 8'h00;
            tog_q <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            if (mod_clk_en) begin
                acc_q <= sum[7:0]; // one bit per cycle
            end
        end
    end
endmodule

//--- tb/tb.sv
// self-checking bench: registers, rates, standby, calibration and coefficients
`timescale 1ns/1ns
module tb;
    logic core_clk, resetn, hsel, hwrite, hreadyout, hresp, mod_bit, mod_clk_en, samp_en;
    logic chan_sel, cal_sys, standby, result_stb;
    logic [31:0] haddr, hwdata, hrdata, rd, off_c, gain_c, ones_w, rnd;
    logic [1:0] htrans, cal_input;
    logic [2:0] cap_ratio_sel;
    logic [8:0] density;
    logic [7:0] addr_tab [5] = '{sdc_pkg::REG_CTRL, sdc_pkg::REG_STATUS, sdc_pkg::REG_OFFSET, sdc_pkg::REG_GAIN, 8'h14};
    logic [31:0] exp_tab [5] = '{32'(sdc_pkg::FS_DEFAULT), 32'h0, 32'h0, {8'h00, sdc_pkg::GAIN_UNITY}, 32'h0};
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    longint span;
    sdc_ctrl #(.BG_WORDS(2), .FIFO_DEPTH(16)) sdc_ctrl_inst (
        .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .mod_bit(mod_bit), .mod_clk_en(mod_clk_en), .samp_en(samp_en),
        .cap_ratio_sel(cap_ratio_sel), .chan_sel(chan_sel), .cal_input(cal_input), .cal_sys(cal_sys),
        .standby(standby), .result_stb(result_stb));
    sdc_mod_model sdc_mod_model_inst (.core_clk(core_clk), .resetn(resetn), .mod_clk_en(mod_clk_en),
        .cal_input(cal_input), .density(density), .mod_bit(mod_bit));
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 150000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one ahb-lite single word transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        r = hrdata;
    endtask
    // drain old words, then fetch the next fresh one only once it is there
    task automatic get_word(output logic [31:0] w);
        xfer(1'b0, sdc_pkg::REG_STATUS, 32'h0, w);
        while (w[0] === 1'b1) begin
            xfer(1'b0, sdc_pkg::REG_DATA, 32'h0, w);
            xfer(1'b0, sdc_pkg::REG_STATUS, 32'h0, w);
        end
        while (w[0] !== 1'b1) xfer(1'b0, sdc_pkg::REG_STATUS, 32'h0, w);
        xfer(1'b0, sdc_pkg::REG_DATA, 32'h0, w); // paced reads
    endtask
    task automatic sync_mod();
        @(posedge core_clk);
        while (mod_clk_en !== 1'b1) @(posedge core_clk);
    endtask
    // reference correction: offset removed, then scaled by the gain coefficient
    function automatic logic [31:0] exp_corr(input logic [31:0] raw, input logic [31:0] off, input logic [31:0] g);
        longint d;
        d = (longint'($signed(raw)) - longint'($signed(off))) * longint'(g);
        return 32'(d >>> 22);
    endfunction
    // main sequence
    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        density = 9'd256;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        void'($urandom(18215));
        xfer(1'b1, 8'h14, $urandom, rd);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, addr_tab[i], 32'h0, rd);
            check(rd, exp_tab[i]); // reset values and hole
        end
        xfer(1'b1, sdc_pkg::REG_CTRL, 32'h5, rd);
        xfer(1'b0, sdc_pkg::REG_CTRL, 32'h0, rd);
        check({20'h0, rd[11:0]}, 32'(sdc_pkg::FS_MIN)); // low clamp
        xfer(1'b1, sdc_pkg::REG_CTRL, 32'hfff, rd);
        xfer(1'b0, sdc_pkg::REG_CTRL, 32'h0, rd);
        check({20'h0, rd[11:0]}, 32'(sdc_pkg::FS_MAX)); // high clamp
        sync_mod();
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (mod_clk_en !== 1'b1);
        check(32'(n), 32'(sdc_pkg::MOD_DIV)); // modulator period
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, sdc_pkg::REG_CTRL, (32'(i) << sdc_pkg::CTRL_GAIN_LSB) | (32'(i % 2) << sdc_pkg::CTRL_CHAN_BIT)
                | 32'(sdc_pkg::FS_MIN), rd);
            sync_mod();
            n = 0;
            repeat (sdc_pkg::MOD_DIV) begin
                @(posedge core_clk);
                if (samp_en === 1'b1) n++;
            end
            check(32'(n), 32'(2 << (i > 3 ? 3 : i))); // samples per cycle
            check({28'h0, chan_sel, cap_ratio_sel}, 32'(i) | 32'(i % 2) << 3); // capacitor scaling
        end
        xfer(1'b1, sdc_pkg::REG_CTRL, (32'h1 << sdc_pkg::CTRL_STBY_BIT) | 32'(sdc_pkg::FS_MIN), rd);
        n = 0;
        repeat (1024) begin
            @(posedge core_clk);
            if (mod_clk_en !== 1'b0 || samp_en !== 1'b0) n++;
        end
        check(32'(n), 32'h0); // no activity
        xfer(1'b0, sdc_pkg::REG_STATUS, 32'h0, rd);
        check({29'h0, hresp, standby, rd[3]}, 32'h3); // standby shown
        // system calibration straight out of standby, no idle needed
        xfer(1'b1, sdc_pkg::REG_CTRL, (32'h1 << sdc_pkg::CTRL_GO_BIT) | (32'h1 << sdc_pkg::CTRL_CALM_LSB)
            | 32'(sdc_pkg::FS_MIN), rd); // start at any time
        while (cal_input !== 2'd1) @(posedge core_clk);
        check({31'h0, cal_sys}, 32'h1); // system mode
        xfer(1'b0, sdc_pkg::REG_STATUS, 32'h0, rd);
        check({31'h0, rd[1]}, 32'h1); // busy
        while (result_stb !== 1'b1) @(posedge core_clk);
        @(posedge core_clk);
        check({31'h0, result_stb}, 32'h0); // single pulse
        n = 1;
        while (result_stb !== 1'b1) begin
            @(posedge core_clk);
            n++;
        end
        check(32'(n), 32'(sdc_pkg::FS_MIN * sdc_pkg::MOD_DIV)); // word rate
        while (cal_input !== 2'd2) @(posedge core_clk);
        while (cal_input !== 2'd0) @(posedge core_clk);
        repeat (24) @(posedge core_clk);
        check({31'h0, cal_sys}, 32'h0); // back to normal
        xfer(1'b0, sdc_pkg::REG_OFFSET, 32'h0, rd);
        off_c = rd;
        xfer(1'b0, sdc_pkg::REG_GAIN, 32'h0, rd);
        gain_c = rd;
        xfer(1'b1, sdc_pkg::REG_OFFSET, 32'h0, rd);
        xfer(1'b1, sdc_pkg::REG_GAIN, {8'h00, sdc_pkg::GAIN_UNITY}, rd);
        get_word(ones_w);
        span = longint'($signed(ones_w)) - longint'($signed(off_c));
        check({31'h0, span > 0}, 32'h1); // full above zero
        span = (longint'(1) << 45) / span;
        check(gain_c, span > 64'hff_ffff ? 32'h00ff_ffff : 32'(span)); // gain coef saturates
        rnd = $urandom_range(64, 1);
        xfer(1'b1, sdc_pkg::REG_OFFSET, rnd, rd);
        xfer(1'b1, sdc_pkg::REG_GAIN, {7'h00, sdc_pkg::GAIN_UNITY, 1'b0}, rd);
        xfer(1'b0, sdc_pkg::REG_OFFSET, 32'h0, rd);
        check(rd, rnd); // readback
        get_word(rd);
        check(rd, exp_corr(ones_w, rnd, {7'h00, sdc_pkg::GAIN_UNITY, 1'b0})); // host coefs used
        xfer(1'b0, sdc_pkg::REG_STATUS, 32'h0, rd);
        check({31'h0, rd[2]}, 32'h1); // settled flag
        report_and_stop();
    end
endmodule
